// ===== shared/cmpt_decode_pkg.sv
// Behaviour
// - Compaction flag bit 29 set means 64-bit compact, clear means 128-bit native.
// - Compact index fields look up tables, except 39:35 with immediate second source; results merge into a 128-bit native word.
// - Jump offsets count quadwords: compact advances one unit, native two.
// - Compact 63:56 goes to native 108:101, or 103:96 when second source immediate.
// - Compact 55:48 copies unchanged to native 76:69, first source register.
// - Compact 47:40 copies unchanged to native 60:53, destination register.
// - Non-immediate second source: index 39:35 picks 12-bit entry for native 120:109.
// - Immediate second source: index to native 108:104, bit 39 sign-extended over 127:109.
// - Index 34:30 picks 12-bit entry for first source fields at native 88:77.
// - Index 22:18 picks 15-bit entry spread over subregister and channel fields.
// - Compact bit 28 is reserved zero and maps nowhere.
// - Condition modifier 27:24 copies straight across.
// - Direct two-dimensional layout: stride, width, modifier, register, subregister fields.
// - Direct four-component layout: swizzle 19:16, modifier, register, bit 4, mask 3:0.
// - Indirect four-component layout: stride, swizzle, mode, pointer, offset 9:4, mask.
// - Indirect two-dimensional layout: stride, width, mode, pointer, byte offset 9:0.
// - Immediate second source ignores all operand fields of the word.
// - Immediate second source takes the whole word as the immediate value.
// - Message-send takes bit 31 of the word as end-of-thread flag.
package cmpt_decode_pkg;
   localparam int NATIVE_W = 128;
   localparam int COMPACT_W = 64;
   localparam int TABLE_DEPTH = 32;
   localparam int IDX_W = 5;
   localparam int OPERAND_ENTRY_W = 12;
   localparam int SUBREG_ENTRY_W = 15;
   localparam int CMPT_FLAG_POS = 29;
   localparam int CMPT_RSVD_POS = 28;
   localparam int ACC_WR_CMPT_POS = 23;
   localparam int ACC_WR_NATIVE_POS = 28;
   localparam int DW3_LSB = 96;
   localparam int ADDR_MODE_POS = 15;
   localparam int EOT_POS = 31;
   localparam int SIGN_W = 19;
   localparam logic [1:0] STEP_COMPACT = 2'h1;
   localparam logic [1:0] STEP_NATIVE = 2'h2;
   // APB map
   localparam int ADDR_W = 12;
   localparam logic [11:0] SRC1_TABLE_BASE = 12'h000;
   localparam logic [11:0] SRC0_TABLE_BASE = 12'h080;
   localparam logic [11:0] SUBREG_TABLE_BASE = 12'h100;
   localparam logic [11:0] STATUS_ADDR = 12'h180;
   localparam logic [11:0] FLAGS_ADDR = 12'h184;
   localparam logic [11:0] TABLE_SPAN_MASK = 12'hf80;

   typedef enum logic [3:0] {
      DIRECT_TWO_DIM = 4'h1,
      DIRECT_FOUR_COMP = 4'h2,
      INDIRECT_FOUR_COMP = 4'h4,
      INDIRECT_TWO_DIM = 4'h8
   } layout_type;

   typedef struct packed {
      logic is_immediate;
      logic [31:0] immediate_word;
      logic end_of_thread_flag;
      logic addressing_select;
      logic [3:0] vertical_stride;
      logic [2:0] width;
      logic [1:0] horizontal_stride;
      logic [1:0] source_modifier;
      logic [7:0] register_number;
      logic [4:0] subregister_number;
      logic [3:0] channel_swizzle;
      logic [3:0] channel_write_mask;
      logic [2:0] address_pointer_subregister;
      logic [9:0] address_offset_immediate;
   } src1_fields_type;
endpackage

// ===== hdl/cmpt_decode.sv
`timescale 1ns/1ns
module cmpt_decode
   import cmpt_decode_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_instr_valid,
   input wire logic [NATIVE_W-1:0] i_instr,
   input wire logic i_src1_immediate,
   input wire logic i_four_component,
   input wire logic i_is_send,
   output logic o_valid,
   output logic [NATIVE_W-1:0] o_native,
   output logic o_was_compact,
   output logic [1:0] o_ip_step,
   output layout_type o_layout,
   output src1_fields_type o_src1
);
   logic [OPERAND_ENTRY_W-1:0] src1_table [TABLE_DEPTH];
   logic [OPERAND_ENTRY_W-1:0] src0_table [TABLE_DEPTH];
   logic [SUBREG_ENTRY_W-1:0] subreg_table [TABLE_DEPTH];
   logic [OPERAND_ENTRY_W-1:0] next_src1_table [TABLE_DEPTH];
   logic [OPERAND_ENTRY_W-1:0] next_src0_table [TABLE_DEPTH];
   logic [SUBREG_ENTRY_W-1:0] next_subreg_table [TABLE_DEPTH];
   logic [31:0] prdata;
   logic [31:0] next_prdata;
   logic slverr;
   logic next_slverr;
   logic [15:0] decoded_count;
   logic [15:0] next_decoded_count;
   logic [15:0] compact_count;
   logic [15:0] next_compact_count;
   logic reserved_seen;
   logic next_reserved_seen;
   logic valid;
   logic next_valid;
   logic [NATIVE_W-1:0] native;
   logic [NATIVE_W-1:0] next_native;
   logic was_compact;
   logic next_was_compact;
   layout_type layout;
   layout_type next_layout;
   src1_fields_type src1;
   src1_fields_type next_src1;
   logic setup;
   logic access;
   logic is_compact;
   logic [IDX_W-1:0] word_idx;

   function automatic logic in_region(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
      return (a & TABLE_SPAN_MASK) == base;
   endfunction

   function automatic src1_fields_type extract_src1(input logic [31:0] dw,
                                                    input layout_type lay,
                                                    input logic imm,
                                                    input logic send);
      src1_fields_type f;
      f = '0;
      f.is_immediate = imm;
      if (imm) begin
         f.immediate_word = dw; // Operand fields ignored
      end else begin
         f.addressing_select = dw[ADDR_MODE_POS];
         f.source_modifier = dw[14:13];
         case (lay)
            DIRECT_TWO_DIM: begin
               f.vertical_stride = dw[24:21];
               f.width = dw[20:18];
               f.horizontal_stride = dw[17:16];
               f.register_number = dw[12:5];
               f.subregister_number = dw[4:0];
            end
            DIRECT_FOUR_COMP: begin
               f.channel_swizzle = dw[19:16];
               f.register_number = dw[12:5];
               f.subregister_number = {dw[4], 4'h0};
               f.channel_write_mask = dw[3:0];
            end
            INDIRECT_FOUR_COMP: begin
               f.vertical_stride = dw[24:21];
               f.channel_swizzle = dw[19:16];
               f.address_pointer_subregister = dw[12:10];
               f.address_offset_immediate = {dw[9:4], 4'h0};
               f.channel_write_mask = dw[3:0];
            end
            INDIRECT_TWO_DIM: begin
               f.vertical_stride = dw[24:21];
               f.width = dw[20:18];
               f.horizontal_stride = dw[17:16];
               f.address_pointer_subregister = dw[12:10];
               f.address_offset_immediate = dw[9:0];
            end
            default: f = '0;
         endcase
      end
      if (send) begin
         f.end_of_thread_flag = dw[EOT_POS];
      end
      return f;
   endfunction

   // Zero-wait slave; read data is staged in the setup cycle
   assign setup = i_psel && !i_penable;
   assign access = i_psel && i_penable;
   assign word_idx = i_paddr[IDX_W+1:2];
   assign o_pready = 1'b1;
   assign o_prdata = prdata;
   assign o_pslverr = slverr && access;

   always_comb begin
      next_src1_table = src1_table;
      next_src0_table = src0_table;
      next_subreg_table = subreg_table;
      next_prdata = prdata;
      next_slverr = slverr;
      next_reserved_seen = reserved_seen;
      if (setup) begin
         next_prdata = '0;
         next_slverr = 1'b0;
         if (in_region(i_paddr, SRC1_TABLE_BASE)) begin
            next_prdata[OPERAND_ENTRY_W-1:0] = src1_table[word_idx];
         end else if (in_region(i_paddr, SRC0_TABLE_BASE)) begin
            next_prdata[OPERAND_ENTRY_W-1:0] = src0_table[word_idx];
         end else if (in_region(i_paddr, SUBREG_TABLE_BASE)) begin
            next_prdata[SUBREG_ENTRY_W-1:0] = subreg_table[word_idx];
         end else if (i_paddr == STATUS_ADDR) begin
            next_prdata = {compact_count, decoded_count};
         end else if (i_paddr == FLAGS_ADDR) begin
            next_prdata[0] = reserved_seen;
         end else begin
            next_slverr = 1'b1;
         end
      end
      if (access && i_pwrite) begin
         if (in_region(i_paddr, SRC1_TABLE_BASE)) begin
            next_src1_table[word_idx] = i_pwdata[OPERAND_ENTRY_W-1:0];
         end else if (in_region(i_paddr, SRC0_TABLE_BASE)) begin
            next_src0_table[word_idx] = i_pwdata[OPERAND_ENTRY_W-1:0];
         end else if (in_region(i_paddr, SUBREG_TABLE_BASE)) begin
            next_subreg_table[word_idx] = i_pwdata[SUBREG_ENTRY_W-1:0];
         end else if (i_paddr == FLAGS_ADDR && i_pwdata[0]) begin
            next_reserved_seen = 1'b0;
         end
      end
      // Set after clear so a same-cycle event is kept
      if (i_instr_valid && is_compact && i_instr[CMPT_RSVD_POS]) begin
         next_reserved_seen = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < TABLE_DEPTH; i++) begin
            src1_table[i] <= '0;
            src0_table[i] <= '0;
            subreg_table[i] <= '0;
         end
         prdata <= '0;
         slverr <= 1'b0;
         reserved_seen <= 1'b0;
      end else begin
         src1_table <= next_src1_table;
         src0_table <= next_src0_table;
         subreg_table <= next_subreg_table;
         prdata <= next_prdata;
         slverr <= next_slverr;
         reserved_seen <= next_reserved_seen;
      end
   end

   assign is_compact = i_instr[CMPT_FLAG_POS];

   always_comb begin
      logic [SUBREG_ENTRY_W-1:0] sub;
      logic [NATIVE_W-1:0] n;
      sub = subreg_table[i_instr[22:18]];
      n = i_instr;
      if (is_compact) begin
         n = '0;
         n[27:24] = i_instr[27:24];
         n[ACC_WR_NATIVE_POS] = i_instr[ACC_WR_CMPT_POS]; // Bit 28 itself maps nowhere
         n[60:53] = i_instr[47:40];
         n[76:69] = i_instr[55:48];
         n[88:77] = src0_table[i_instr[34:30]];
         n[68:64] = sub[9:5];
         n[52:48] = sub[4:0];
         if (i_src1_immediate) begin
            n[103:96] = i_instr[63:56];
            n[108:104] = i_instr[39:35];
            n[127:109] = {SIGN_W{i_instr[39]}};
         end else begin
            n[100:96] = sub[14:10];
            n[108:101] = i_instr[63:56];
            n[120:109] = src1_table[i_instr[39:35]];
         end
      end
      // Layout picked before any field is pulled out
      case ({n[DW3_LSB+ADDR_MODE_POS], i_four_component})
         2'b00: next_layout = DIRECT_TWO_DIM;
         2'b01: next_layout = DIRECT_FOUR_COMP;
         2'b11: next_layout = INDIRECT_FOUR_COMP;
         default: next_layout = INDIRECT_TWO_DIM;
      endcase
      next_native = n;
      next_valid = i_instr_valid;
      next_was_compact = is_compact;
      next_src1 = extract_src1(n[NATIVE_W-1:DW3_LSB], next_layout, i_src1_immediate, i_is_send);
      next_decoded_count = decoded_count + 16'(i_instr_valid);
      next_compact_count = compact_count + 16'(i_instr_valid && is_compact);
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         valid <= 1'b0;
         native <= '0;
         was_compact <= 1'b0;
         layout <= DIRECT_TWO_DIM;
         src1 <= '0;
         decoded_count <= '0;
         compact_count <= '0;
      end else begin
         valid <= next_valid;
         native <= next_native;
         was_compact <= next_was_compact;
         layout <= next_layout;
         src1 <= next_src1;
         decoded_count <= next_decoded_count;
         compact_count <= next_compact_count;
      end
   end

   assign o_valid = valid;
   assign o_native = native;
   assign o_was_compact = was_compact;
   assign o_ip_step = was_compact ? STEP_COMPACT : STEP_NATIVE;
   assign o_layout = layout;
   assign o_src1 = src1;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   sequence s_compact_in;
      i_instr_valid && i_instr[CMPT_FLAG_POS];
   endsequence
   sequence s_compact_imm;
      s_compact_in ##0 i_src1_immediate;
   endsequence
   sequence s_compact_reg;
      s_compact_in ##0 !i_src1_immediate;
   endsequence

   a_compact_ip_step: assert property (s_compact_in |=> o_valid && o_ip_step == 2'h1)
      else $error("compact step not one");
   a_native_ip_step: assert property (i_instr_valid && !i_instr[29] |=> o_ip_step == 2'h2)
      else $error("native step not two");
   a_native_passes: assert property (i_instr_valid && !i_instr[29] |=> o_native == $past(i_instr))
      else $error("native word altered");
   a_dst_copy: assert property (s_compact_in |=> o_native[60:53] == $past(i_instr[47:40]))
      else $error("destination register lost");
   a_src0_copy: assert property (s_compact_in |=> o_native[76:69] == $past(i_instr[55:48]))
      else $error("first source register lost");
   a_cond_copy: assert property (s_compact_in |=> o_native[27:24] == $past(i_instr[27:24]))
      else $error("condition modifier moved");
   a_reserved_unmapped: assert property (s_compact_in |=> o_native[28] == $past(i_instr[23]))
      else $error("reserved bit leaked");
   a_imm_sign_ext: assert property (s_compact_imm |=>
      o_native[127:109] == {19{$past(i_instr[39])}} && o_native[103:96] == $past(i_instr[63:56]))
      else $error("immediate extension wrong");
   a_src1_reg_place: assert property (s_compact_reg |=> o_native[108:101] == $past(i_instr[63:56]))
      else $error("second source register misplaced");
   a_imm_word_out: assert property (o_valid && o_src1.is_immediate |->
      o_src1.immediate_word == o_native[127:96] && o_src1.register_number == 8'h00)
      else $error("immediate word not taken");
   a_eot_flag: assert property (i_instr_valid && i_is_send && !i_instr[29] |=>
      o_src1.end_of_thread_flag == $past(i_instr[127]))
      else $error("end of thread flag wrong");
   a_layout_pick: assert property (i_instr_valid && !i_instr[29] && !i_instr[111]
      && i_four_component |=> o_layout == DIRECT_FOUR_COMP)
      else $error("layout select wrong");
   a_src1_lookup: assert property (s_compact_reg |=>
      o_native[120:109] == $past(src1_table[i_instr[39:35]]))
      else $error("second source entry wrong");
   a_src0_lookup: assert property (s_compact_in |=>
      o_native[88:77] == $past(src0_table[i_instr[34:30]]))
      else $error("first source entry wrong");
   a_subreg_spread: assert property (s_compact_reg |=>
      {o_native[100:96], o_native[68:64], o_native[52:48]} == $past(subreg_table[i_instr[22:18]]))
      else $error("subregister entry spread wrong");
   a_imm_index: assert property (s_compact_imm |=> o_native[108:104] == $past(i_instr[39:35]))
      else $error("immediate index misplaced");
   a_reserved_sticky: assert property (s_compact_in ##0 i_instr[CMPT_RSVD_POS] |=>
      reserved_seen)
      else $error("reserved bit event lost");
   a_valid_next: assert property (i_instr_valid |=> o_valid)
      else $error("result valid missing");
   a_four_comp_sub: assert property (o_valid && o_layout == DIRECT_FOUR_COMP
      && !o_src1.is_immediate |-> o_src1.subregister_number[3:0] == 4'h0)
      else $error("four component subregister wrong");
endmodule // cmpt_decode

// ===== tb/instr_feeder.sv
`timescale 1ns/1ns
module instr_feeder
   import cmpt_decode_pkg::*;
(
   input wire logic i_clk,
   output logic o_instr_valid,
   output logic [NATIVE_W-1:0] o_instr,
   output logic o_src1_immediate,
   output logic o_four_component,
   output logic o_is_send
);
   logic [NATIVE_W+2:0] q[$];
   logic [NATIVE_W+2:0] head;

   initial begin
      o_instr_valid = 1'b0;
      o_instr = '0;
      o_src1_immediate = 1'b0;
      o_four_component = 1'b0;
      o_is_send = 1'b0;
   end

   // No legality check on queued words; producers use native form for three-source ops and options
   task automatic push(input logic [NATIVE_W+2:0] item);
      q.push_back(item);
   endtask

   // One word per clock while queued; idle lines churn so stale data never looks valid
   always @(posedge i_clk) begin
      if (q.size() > 0) begin
         head = q.pop_front();
         o_instr_valid <= 1'b1;
         {o_instr, o_src1_immediate, o_four_component, o_is_send} <= head;
      end else begin
         o_instr_valid <= 1'b0;
         o_instr <= ~o_instr;
         o_src1_immediate <= ~o_src1_immediate;
         o_four_component <= ~o_four_component;
         o_is_send <= ~o_is_send;
      end
   end
endmodule // instr_feeder

// ===== tb/cmpt_decode_tb.sv
`timescale 1ns/1ns
module cmpt_decode_tb;
   import cmpt_decode_pkg::*;
   typedef struct packed {
      logic [127:0] nat;
      src1_fields_type s1;
      layout_type lay;
      logic cmp;
   } exp_type;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [ADDR_W-1:0] i_paddr = '0;
   logic [31:0] i_pwdata = '0;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr, o_valid, o_was_compact, vld, imm, four, snd;
   logic [127:0] o_native, ins;
   logic [1:0] o_ip_step;
   layout_type o_layout;
   src1_fields_type o_src1;
   exp_type exp_q[$];
   int fails = 0;
   int cmp_count = 0;
   int n_dec = 0;
   int n_cmp = 0;
   logic [11:0] t1 [32] = '{default: '0};
   logic [11:0] t0 [32] = '{default: '0};
   logic [14:0] ts [32] = '{default: '0};

   always #5 i_clk = ~i_clk;

   instr_feeder instr_feeder_i (.i_clk(i_clk), .o_instr_valid(vld), .o_instr(ins),
      .o_src1_immediate(imm), .o_four_component(four), .o_is_send(snd));
   cmpt_decode cmpt_decode_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_instr_valid(vld), .i_instr(ins), .i_src1_immediate(imm),
      .i_four_component(four), .i_is_send(snd), .o_valid(o_valid), .o_native(o_native),
      .o_was_compact(o_was_compact), .o_ip_step(o_ip_step), .o_layout(o_layout),
      .o_src1(o_src1));

   task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One APB transfer; read data is checked only for reads
   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      input logic [31:0] expd, input logic experr);
      int n;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      if (o_pready !== 1'b1) begin
         fails++;
         complete_run();
      end
      if (!wr) begin
         chk(o_prdata, expd, "read data");
      end
      chk(o_pslverr, experr, "slave error");
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   function automatic logic [127:0] expand(input logic [63:0] c, input logic im);
      logic [127:0] n;
      logic [14:0] s;
      n = '0;
      s = ts[c[22:18]];
      n[88:77] = t0[c[34:30]];
      n[76:69] = c[55:48];
      n[68:64] = s[9:5];
      n[60:53] = c[47:40];
      n[52:48] = s[4:0];
      n[28] = c[23];
      n[27:24] = c[27:24];
      if (im) begin
         n[127:109] = {19{c[39]}};
         n[108:104] = c[39:35];
         n[103:96] = c[63:56];
      end else begin
         n[120:109] = t1[c[39:35]];
         n[108:101] = c[63:56];
         n[100:96] = s[14:10];
      end
      return n;
   endfunction

   function automatic src1_fields_type fields(input logic [31:0] w, input logic fc,
                                              input logic im, input logic sd);
      src1_fields_type s;
      s = '0;
      s.end_of_thread_flag = sd & w[31];
      if (im) begin
         s.is_immediate = 1'b1;
         s.immediate_word = w;
         return s;
      end
      s.addressing_select = w[15];
      s.source_modifier = w[14:13];
      s.vertical_stride = (w[15] || !fc) ? w[24:21] : 4'h0;
      s.width = fc ? 3'h0 : w[20:18];
      s.horizontal_stride = fc ? 2'h0 : w[17:16];
      s.channel_swizzle = fc ? w[19:16] : 4'h0;
      s.channel_write_mask = fc ? w[3:0] : 4'h0;
      if (!w[15]) begin
         s.register_number = w[12:5];
         s.subregister_number = fc ? {w[4], 4'h0} : w[4:0];
      end else begin
         s.address_pointer_subregister = w[12:10];
         s.address_offset_immediate = fc ? {w[9:4], 4'h0} : w[9:0];
      end
      return s;
   endfunction

   task automatic put(input logic [127:0] in, input logic im, input logic fc, input logic sd);
      exp_type e;
      e.cmp = in[CMPT_FLAG_POS];
      e.nat = e.cmp ? expand(in[63:0], im) : in;
      e.s1 = fields(e.nat[127:96], fc, im, sd);
      e.lay = fc ? (e.nat[111] ? INDIRECT_FOUR_COMP : DIRECT_FOUR_COMP)
                 : (e.nat[111] ? INDIRECT_TWO_DIM : DIRECT_TWO_DIM);
      exp_q.push_back(e);
      instr_feeder_i.push({in, im, fc, sd});
      n_dec++;
      n_cmp += e.cmp;
   endtask

   always @(negedge i_clk) begin
      exp_type e;
      if (o_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(1'b1, 1'b0, "spurious result");
         end else begin
            e = exp_q.pop_front();
            chk(o_native, e.nat, "native word");
            chk(o_src1, e.s1, "second source");
            chk(o_layout, e.lay, "layout");
            chk(o_was_compact, e.cmp, "compact flag");
            chk(o_ip_step, e.cmp ? STEP_COMPACT : STEP_NATIVE, "ip step");
         end
      end
   end

   initial begin
      int i;
      logic [31:0] w;
      repeat (2) @(posedge i_clk);
      #1;
      chk(o_ip_step, STEP_NATIVE, "reset step");
      chk(o_layout, DIRECT_TWO_DIM, "reset layout");
      chk({o_pready, o_valid}, 2'h2, "reset flags");
      @(posedge i_clk);
      i_rst_b <= 1'b1;
      acc(1'b0, SRC1_TABLE_BASE + 12'h014, '0, '0, 1'b0);
      t1[5] = 12'habc;
      t0[3] = 12'hfff;
      ts[7] = 15'h5b3d;
      acc(1'b1, SRC1_TABLE_BASE + 12'h014, {20'h0, t1[5]}, '0, 1'b0);
      acc(1'b1, SRC0_TABLE_BASE + 12'h00c, 32'hffff_ffff, '0, 1'b0);
      acc(1'b1, SUBREG_TABLE_BASE + 12'h01c, {17'h0, ts[7]}, '0, 1'b0);
      acc(1'b0, SRC0_TABLE_BASE + 12'h00c, '0, 32'h0000_0fff, 1'b0);
      acc(1'b0, 12'h200, '0, '0, 1'b1);
      acc(1'b1, 12'h1fc, 32'h1, '0, 1'b1);
      // Upper half carries junk: compact words use bits 63:0 only
      put({64'hdead_beef_0bad_f00d, 8'h9c, 8'h3e, 8'h71, 5'd5, 5'd3, 2'b10, 4'ha, 1'b1,
           5'd7, 18'h0}, 1'b0, 1'b0, 1'b0);
      put({64'h0, 8'h5d, 8'h11, 8'h22, 5'h13, 5'd3, 2'b10, 4'h3, 1'b0, 5'd7, 18'h0},
          1'b1, 1'b0, 1'b1);
      put({64'h0, 8'h01, 8'h02, 8'h03, 5'd0, 5'd0, 2'b11, 4'h0, 1'b0, 5'd0, 18'h0},
          1'b0, 1'b1, 1'b0);
      for (i = 0; i < 8; i++) begin
         w = 32'ha5c3_5a3c ^ (i * 32'h1357_2469);
         w[15] = i[0];
         put({w, 32'h1357_9bdf, 32'h2468_ace0, 32'h0f0f_0f0f}, i[2], i[1], i[2] ^ i[0]);
      end
      i = 0;
      while (exp_q.size() > 0 && i < 100) begin
         @(posedge i_clk);
         i++;
      end
      chk(exp_q.size(), 0, "results missing");
      acc(1'b0, STATUS_ADDR, '0, {16'(n_cmp), 16'(n_dec)}, 1'b0);
      acc(1'b0, FLAGS_ADDR, '0, 32'h1, 1'b0);
      acc(1'b1, FLAGS_ADDR, 32'h1, '0, 1'b0);
      acc(1'b0, FLAGS_ADDR, '0, 32'h0, 1'b0);
      complete_run();
   end
endmodule // cmpt_decode_tb
